/* inc/rsi_pkg.sv */
// constants of the serial setup and indirect access block
// How it works
// - framing settings reach the link only when power comes up
// - partial batch init leaves the stored framing settings alone
// - full batch init restores stored framing settings to their defaults
// - slave id defaults to -1, meaning the address switch sets the address
// - rate is a code; default code 4 selects 115200 bps
// - word order code; default 0 puts the high word at the even address
// - parity code defaults to 1, even parity
// - stop bit code defaults to 0, one stop bit
// - reply waits a set time, default 3.0 ms, before transmitting
// - silent interval setting; default 0 derives it from the rate
// - alarm, error and response settings act at once when written
// - timeout alarm condition is settable; 0 turns monitoring off
// - error alarm raised when errors reach the setting, default 3
// - error information warning raised at its setting, default 3
// - error response mode; default 1 returns an exception response
// - indirect table has 32 entries, 0 to 31, each naming an item
// - indirect area is contiguous so one request reaches scattered items
// - reads and writes to the indirect area go to the assigned item
package rsi_pkg;
	// apb byte offsets
	localparam logic [7:0] OFS_ID      = 8'h00;
	localparam logic [7:0] OFS_RATE    = 8'h04;
	localparam logic [7:0] OFS_ORDER   = 8'h08;
	localparam logic [7:0] OFS_PARITY  = 8'h0c;
	localparam logic [7:0] OFS_STOP    = 8'h10;
	localparam logic [7:0] OFS_TXWAIT  = 8'h14;
	localparam logic [7:0] OFS_SILENT  = 8'h18;
	localparam logic [7:0] OFS_TMO     = 8'h1c;
	localparam logic [7:0] OFS_ERRALM  = 8'h20;
	localparam logic [7:0] OFS_ERRINF  = 8'h24;
	localparam logic [7:0] OFS_ERRMODE = 8'h28;
	localparam logic [7:0] OFS_MAINT   = 8'h2c;
	localparam logic [7:0] OFS_STATUS  = 8'h30;
	localparam logic [7:0] OFS_ACTIVE  = 8'h34;
	localparam logic [7:0] OFS_TABLE   = 8'h80;
	// reset values
	localparam logic [15:0] RST_ID      = 16'hffff;
	localparam logic [2:0]  RST_RATE    = 3'h4;
	localparam logic [1:0]  RST_ORDER   = 2'h0;
	localparam logic [1:0]  RST_PARITY  = 2'h1;
	localparam logic        RST_STOP    = 1'h0;
	localparam logic [15:0] RST_TXWAIT  = 16'h001e; // 3.0 ms in 0.1 ms units
	localparam logic [15:0] RST_SILENT  = 16'h0000;
	localparam logic [15:0] RST_TMO     = 16'h0000;
	localparam logic [7:0]  RST_ERRALM  = 8'h03;
	localparam logic [7:0]  RST_ERRINF  = 8'h03;
	localparam logic        RST_ERRMODE = 1'h1;
	// maintenance commands
	localparam logic [1:0] MNT_PARTIAL = 2'h1;
	localparam logic [1:0] MNT_ALL     = 2'h2;
	localparam logic [1:0] MNT_ACLR    = 2'h3;
	// status bits
	localparam int ST_ALARM = 0;
	localparam int ST_INFO  = 1;
	localparam int ST_TMO   = 2;
	// timing
	localparam int CLK_MHZ    = 250;
	localparam int UNIT_US    = 100;  // wait and silent settings count 0.1 ms
	localparam int TMO_UNIT_US = 1000; // timeout setting counts 1 ms
	localparam int UNIT_CYC   = UNIT_US * CLK_MHZ;
	localparam int TMO_CYC    = TMO_UNIT_US * CLK_MHZ;
	// indirect table
	localparam int IND_N = 32;
	localparam logic [15:0] IND_ASSIGN_BASE = 16'h1200;
	localparam logic [15:0] IND_AREA_BASE   = 16'h1300;
	localparam logic [15:0] IND_DEF [0:14] = '{16'h0240, 16'h0380, 16'h0300, 16'h0340,
		16'h003e, 16'h0062, 16'h0067, 16'h006c, 16'h003f, 16'h0040, 16'h007b,
		16'h007c, 16'h00a3, 16'h009d, 16'h007f};
	// derived silent interval per rate code, 0.1 ms units (codes 0..7)
	localparam logic [15:0] SIL_AUTO [0:7] = '{16'h0028, 16'h0014, 16'h000a, 16'h0012,
		16'h0012, 16'h0012, 16'h0012, 16'h0012};
	typedef enum logic [1:0] {
		RW_IDLE = 2'b01,
		RW_WAIT = 2'b10
	} rsi_rw_t;
endpackage

/* logic/rsi_timer.sv */
// down counter that pulses once when a loaded cycle count has run out
module rsi_timer #(
	parameter int W = 40
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic [W-1:0] load,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_reg, cnt_next;
	logic         busy_reg, busy_next, done_reg, done_next;

	always_comb begin
		cnt_next  = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (stop) begin
			busy_next = 1'b0;
		end else if (start) begin
			cnt_next  = load;
			busy_next = 1'b1;
		end else if (busy_reg) begin
			if (cnt_reg <= W'(1)) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule // rsi_timer

/* logic/rsi_setup.sv */
// serial setup registers, error supervision, reply wait and indirect redirection
module rsi_setup
	import rsi_pkg::*;
#(parameter int UNIT_CYCLES = UNIT_CYC, parameter int TMO_CYCLES = TMO_CYC) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  addr_switch,
	input  wire logic        frame_ok,
	input  wire logic        frame_err,
	input  wire logic        reply_req,
	input  wire logic        acc_req,
	input  wire logic        acc_we,
	input  wire logic [15:0] acc_addr,
	input  wire logic [15:0] acc_wdata,
	output logic             acc_valid,
	output logic             acc_ind,
	output logic      [15:0] acc_target,
	output logic      [7:0]  slave_addr,
	output logic      [2:0]  rate_code,
	output logic      [1:0]  word_order,
	output logic      [1:0]  parity_code,
	output logic             stop_code,
	output logic      [15:0] silent_eff,
	output logic             tx_start,
	output logic             err_alarm,
	output logic             err_info,
	output logic             tmo_alarm,
	output logic             exc_resp
);
	import rsi_pkg::*;

	// stored settings (software side)
	logic [15:0] id_reg, id_next, txw_reg, txw_next, sil_reg, sil_next, tmo_reg, tmo_next;
	logic [2:0]  rate_reg, rate_next;
	logic [1:0]  ord_reg, ord_next, par_reg, par_next;
	logic        stp_reg, stp_next, emode_reg, emode_next;
	logic [7:0]  ealm_reg, ealm_next, einf_reg, einf_next;
	// active shadows
	logic [15:0] a_txw_reg, a_txw_next;
	logic        load_reg, load_next;
	logic [7:0]  slv_reg, slv_next;
	logic [2:0]  a_rate_reg, a_rate_next;
	logic [1:0]  a_ord_reg, a_ord_next, a_par_reg, a_par_next;
	logic        a_stp_reg, a_stp_next;
	logic [15:0] a_sil_reg, a_sil_next;
	// bus
	logic [31:0] rd_reg, rd_next, rmux;
	logic        rdy_reg, rdy_next, err_reg, err_next, hit;
	logic        wr;
	logic [1:0]  mnt;
	// supervision
	logic [7:0]  ecnt_reg, ecnt_next;
	logic        alm_reg, alm_next, inf_reg, inf_next, tmo_a_reg, tmo_a_next;
	rsi_rw_t     rw_reg, rw_next;
	logic        tx_reg, tx_next, wdone, tdone;
	// indirect
	logic [15:0] tbl_reg [0:IND_N-1];
	logic        av_reg, ai_reg;
	logic [15:0] at_reg, tgt;
	logic        in_area, in_assign;
	logic [4:0]  ent;

	assign wr  = psel & penable & rdy_reg & pwrite;
	assign mnt = (wr && paddr == OFS_MAINT) ? pwdata[1:0] : 2'h0;

	// register writes; partial and full init commands restore defaults
	always_comb begin
		id_next = id_reg; rate_next = rate_reg; ord_next = ord_reg; par_next = par_reg;
		stp_next = stp_reg; txw_next = txw_reg; sil_next = sil_reg; tmo_next = tmo_reg;
		ealm_next = ealm_reg; einf_next = einf_reg; emode_next = emode_reg;
		if (mnt == MNT_PARTIAL || mnt == MNT_ALL) begin
			tmo_next = RST_TMO; ealm_next = RST_ERRALM;
			einf_next = RST_ERRINF; emode_next = RST_ERRMODE; // framing kept unless full init
		end
		if (mnt == MNT_ALL) begin
			id_next = RST_ID; rate_next = RST_RATE; ord_next = RST_ORDER;
			par_next = RST_PARITY; stp_next = RST_STOP;
			txw_next = RST_TXWAIT; sil_next = RST_SILENT;
		end
		if (wr) begin
			if (paddr == OFS_ID) begin
				id_next = pwdata[15:0];
			end else if (paddr == OFS_RATE) begin
				rate_next = pwdata[2:0];
			end else if (paddr == OFS_ORDER) begin
				ord_next = pwdata[1:0];
			end else if (paddr == OFS_PARITY) begin
				par_next = pwdata[1:0];
			end else if (paddr == OFS_STOP) begin
				stp_next = pwdata[0];
			end else if (paddr == OFS_TXWAIT) begin
				txw_next = pwdata[15:0];
			end else if (paddr == OFS_SILENT) begin
				sil_next = pwdata[15:0];
			end else if (paddr == OFS_TMO) begin
				tmo_next = pwdata[15:0];
			end else if (paddr == OFS_ERRALM) begin
				ealm_next = pwdata[7:0];
			end else if (paddr == OFS_ERRINF) begin
				einf_next = pwdata[7:0];
			end else if (paddr == OFS_ERRMODE) begin
				emode_next = pwdata[0];
			end
		end
	end

	// shadows load in the first cycle after reset release and never again
	always_comb begin
		load_next = 1'b0;
		a_rate_next = a_rate_reg; a_ord_next = a_ord_reg; a_par_next = a_par_reg;
		a_stp_next = a_stp_reg; a_txw_next = a_txw_reg; a_sil_next = a_sil_reg;
		slv_next = slv_reg;
		if (load_reg) begin
			a_rate_next = rate_reg; a_ord_next = ord_reg; a_par_next = par_reg;
			a_stp_next = stp_reg; a_txw_next = txw_reg;
			a_sil_next = (sil_reg == 16'h0000) ? SIL_AUTO[rate_reg] : sil_reg;
			slv_next = (id_reg == RST_ID) ? addr_switch : id_reg[7:0];
		end
	end

	// read mux and bus answer; one wait state per transfer
	always_comb begin
		hit  = 1'b1;
		rmux = 32'h0000_0000;
		if (paddr == OFS_ID) begin
			rmux = {16'h0000, id_reg};
		end else if (paddr == OFS_RATE) begin
			rmux = {29'h0, rate_reg};
		end else if (paddr == OFS_ORDER) begin
			rmux = {30'h0, ord_reg};
		end else if (paddr == OFS_PARITY) begin
			rmux = {30'h0, par_reg};
		end else if (paddr == OFS_STOP) begin
			rmux = {31'h0, stp_reg};
		end else if (paddr == OFS_TXWAIT) begin
			rmux = {16'h0000, txw_reg};
		end else if (paddr == OFS_SILENT) begin
			rmux = {16'h0000, sil_reg};
		end else if (paddr == OFS_TMO) begin
			rmux = {16'h0000, tmo_reg};
		end else if (paddr == OFS_ERRALM) begin
			rmux = {24'h0, ealm_reg};
		end else if (paddr == OFS_ERRINF) begin
			rmux = {24'h0, einf_reg};
		end else if (paddr == OFS_ERRMODE) begin
			rmux = {31'h0, emode_reg};
		end else if (paddr == OFS_MAINT) begin
			rmux = 32'h0000_0000;
		end else if (paddr == OFS_STATUS) begin
			rmux = {16'h0, ecnt_reg, 5'h0, tmo_a_reg, inf_reg, alm_reg};
		end else if (paddr == OFS_ACTIVE) begin
			rmux = {16'h0, slv_reg, a_stp_reg, a_par_reg, a_ord_reg, a_rate_reg};
		end else if (paddr[7] == OFS_TABLE[7] && paddr[1:0] == 2'h0) begin
			rmux = {16'h0000, tbl_reg[paddr[6:2]]};
		end else begin
			hit = 1'b0;
		end
		rdy_next = psel & penable & ~rdy_reg;
		rd_next  = (rdy_next && !pwrite && hit) ? rmux : 32'h0000_0000;
		err_next = rdy_next & ~hit;
	end

	// error supervision; an event in the clear cycle wins
	always_comb begin
		ecnt_next = ecnt_reg;
		if (frame_err) begin
			ecnt_next = (ecnt_reg == 8'hff) ? ecnt_reg : ecnt_reg + 8'h01;
		end else if (frame_ok) begin
			ecnt_next = 8'h00;
		end
		alm_next = alm_reg;
		if (mnt == MNT_ACLR) begin
			alm_next = 1'b0;
			tmo_a_next = 1'b0;
		end else begin
			tmo_a_next = tmo_a_reg;
		end
		if (ealm_reg != 8'h00 && ecnt_next >= ealm_reg) begin
			alm_next = 1'b1;
		end
		if (tdone && tmo_reg != 16'h0000) begin
			tmo_a_next = 1'b1;
		end
		inf_next = (einf_reg != 8'h00) && (ecnt_next >= einf_reg);
	end

	// reply wait state machine
	always_comb begin
		rw_next = rw_reg;
		tx_next = 1'b0;
		case (rw_reg)
			RW_IDLE: begin
				if (reply_req) begin
					rw_next = RW_WAIT;
				end
			end
			RW_WAIT: begin
				if (wdone) begin
					rw_next = RW_IDLE;
					tx_next = 1'b1;
				end
			end
			default: rw_next = RW_IDLE;
		endcase
	end

	rsi_timer #(.W(40)) u_wait (
		.clk   (clk),
		.rst_n (rst_n),
		.start (reply_req && rw_reg == RW_IDLE),
		.stop  (1'b0),
		.load  (40'(a_txw_reg) * 40'(UNIT_CYCLES)),
		.busy  (),
		.done  (wdone)
	);

	// timeout restarts on every frame; zero setting keeps it stopped
	rsi_timer #(.W(40)) u_tmo (
		.clk   (clk),
		.rst_n (rst_n),
		.start (frame_ok | frame_err),
		.stop  (tmo_reg == 16'h0000),
		.load  (40'(tmo_reg) * 40'(TMO_CYCLES)),
		.busy  (),
		.done  (tdone)
	);

	// indirect redirection: entry holds half of the target address
	assign in_area   = acc_addr[15:6] == IND_AREA_BASE[15:6];
	assign in_assign = acc_addr[15:6] == IND_ASSIGN_BASE[15:6];
	assign ent       = acc_addr[5:1];
	assign tgt       = in_area ? {tbl_reg[ent][14:0], acc_addr[0]} : acc_addr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < IND_N; i++) begin
				tbl_reg[i] <= (i < 15) ? IND_DEF[i] : 16'h0000;
			end
		end else if (mnt == MNT_PARTIAL || mnt == MNT_ALL) begin
			for (int i = 0; i < IND_N; i++) begin
				tbl_reg[i] <= (i < 15) ? IND_DEF[i] : 16'h0000;
			end
		end else if (wr && paddr[7] && paddr[1:0] == 2'h0) begin
			tbl_reg[paddr[6:2]] <= pwdata[15:0];
		end else if (acc_req && acc_we && in_assign && acc_addr[0]) begin
			// only the lower word carries the entry; upper word writes are dropped
			tbl_reg[ent] <= acc_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			av_reg <= 1'b0;
			ai_reg <= 1'b0;
			at_reg <= 16'h0000;
		end else begin
			av_reg <= acc_req;
			ai_reg <= acc_req & in_area;
			at_reg <= acc_req ? tgt : at_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			id_reg <= RST_ID; rate_reg <= RST_RATE; ord_reg <= RST_ORDER;
			par_reg <= RST_PARITY; stp_reg <= RST_STOP; txw_reg <= RST_TXWAIT;
			sil_reg <= RST_SILENT; tmo_reg <= RST_TMO; ealm_reg <= RST_ERRALM;
			einf_reg <= RST_ERRINF; emode_reg <= RST_ERRMODE;
			load_reg <= 1'b1; slv_reg <= 8'h00; a_rate_reg <= RST_RATE;
			a_ord_reg <= RST_ORDER; a_par_reg <= RST_PARITY; a_stp_reg <= RST_STOP;
			a_txw_reg <= RST_TXWAIT; a_sil_reg <= 16'h0000;
			rd_reg <= 32'h0000_0000; rdy_reg <= 1'b0; err_reg <= 1'b0;
			ecnt_reg <= 8'h00; alm_reg <= 1'b0; inf_reg <= 1'b0; tmo_a_reg <= 1'b0;
			rw_reg <= RW_IDLE; tx_reg <= 1'b0;
		end else begin
			id_reg <= id_next; rate_reg <= rate_next; ord_reg <= ord_next;
			par_reg <= par_next; stp_reg <= stp_next; txw_reg <= txw_next;
			sil_reg <= sil_next; tmo_reg <= tmo_next; ealm_reg <= ealm_next;
			einf_reg <= einf_next; emode_reg <= emode_next;
			load_reg <= load_next; slv_reg <= slv_next; a_rate_reg <= a_rate_next;
			a_ord_reg <= a_ord_next; a_par_reg <= a_par_next; a_stp_reg <= a_stp_next;
			a_txw_reg <= a_txw_next; a_sil_reg <= a_sil_next;
			rd_reg <= rd_next; rdy_reg <= rdy_next; err_reg <= err_next;
			ecnt_reg <= ecnt_next; alm_reg <= alm_next; inf_reg <= inf_next;
			tmo_a_reg <= tmo_a_next; rw_reg <= rw_next; tx_reg <= tx_next;
		end
	end

	assign prdata = rd_reg;     assign pready = rdy_reg;    assign pslverr = err_reg;
	assign acc_valid = av_reg;  assign acc_ind = ai_reg;    assign acc_target = at_reg;
	assign slave_addr = slv_reg; assign rate_code = a_rate_reg; assign word_order = a_ord_reg;
	assign parity_code = a_par_reg; assign stop_code = a_stp_reg; assign silent_eff = a_sil_reg;
	assign tx_start = tx_reg;   assign err_alarm = alm_reg; assign err_info = inf_reg;
	assign tmo_alarm = tmo_a_reg; assign exc_resp = emode_reg;

	// assertions
	shadow_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(load_reg) |-> $stable(a_rate_reg) && $stable(a_par_reg) && $stable(a_txw_reg))
		else $error("active framing changed after power-up load");
	shadow_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		load_reg |=> a_rate_reg == $past(rate_reg) && a_ord_reg == $past(ord_reg))
		else $error("shadow not loaded from stored setting");
	partial_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		mnt == MNT_PARTIAL |=> $stable(id_reg) && $stable(rate_reg) && $stable(txw_reg))
		else $error("partial init touched framing settings");
	all_init_a: assert property (@(posedge clk) disable iff (!rst_n)
		mnt == MNT_ALL |=> id_reg == RST_ID && rate_reg == RST_RATE && par_reg == RST_PARITY)
		else $error("full init did not restore framing defaults");
	switch_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		load_reg && id_reg == RST_ID |=> slave_addr == $past(addr_switch))
		else $error("slave address not taken from switch");
	reply_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		tx_start |=> !tx_start)
		else $error("reply start lasted more than one cycle");
	no_early_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
		rw_reg == RW_IDLE && reply_req && a_txw_reg != 16'h0000 |=> !tx_start [*3])
		else $error("reply sent before the wait ran out");
	err_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
		ealm_reg != 8'h00 && ecnt_next >= ealm_reg |=> err_alarm)
		else $error("error alarm missed at threshold");
	err_info_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_ok && !frame_err |=> !err_info)
		else $error("error info not cleared by good frame");
	tmo_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		tmo_reg == 16'h0000 && !tmo_alarm ##1 tmo_reg == 16'h0000 |-> !tmo_alarm)
		else $error("timeout raised while unmonitored");
	redirect_a: assert property (@(posedge clk) disable iff (!rst_n)
		acc_req && in_area |=> acc_ind && acc_target == {$past(tbl_reg[ent][14:0]),
		$past(acc_addr[0])})
		else $error("indirect access not redirected");
	busy_wait_c: cover property (@(posedge clk) disable iff (!rst_n) reply_req ##[1:40] tx_start);
	alarm_c: cover property (@(posedge clk) disable iff (!rst_n) frame_err [*3] ##1 err_alarm);
	ind_c: cover property (@(posedge clk) disable iff (!rst_n) acc_req && in_area);
	unmapped_c: cover property (@(posedge clk) disable iff (!rst_n) pslverr);
endmodule // rsi_setup

/* verification/rsi_host_model.sv */
// host model driving frame events, reply requests and link register accesses
module rsi_host_model
	import rsi_pkg::*;
(
	input  wire logic        clk,
	output logic             frame_ok,
	output logic             frame_err,
	output logic             reply_req,
	output logic             acc_req,
	output logic             acc_we,
	output logic      [15:0] acc_addr,
	output logic      [15:0] acc_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{frame_ok, frame_err, reply_req, acc_req, acc_we} = 5'h00;
		acc_addr = 16'h0000;
		acc_wdata = 16'h0000;
	end
	// one request per address; scattered direct items each need their own
	task automatic access(input logic we, input logic [15:0] a, input logic [15:0] d);
		acc_req <= 1'b1;
		acc_we <= we;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge clk);
		acc_req <= 1'b0;
		// released lines show the inverse so a stale value never looks valid
		acc_addr <= ~a;
		acc_wdata <= ~d;
		// an idle edge keeps a following call from assigning a line twice in one step
		@(posedge clk);
	endtask
	// upper word zero first, then half the target address in the lower word
	task automatic assign_entry(input int n, input logic [15:0] half);
		access(1'b1, IND_ASSIGN_BASE + 16'(2 * n), 16'h0000);
		access(1'b1, IND_ASSIGN_BASE + 16'(2 * n + 1), half);
	endtask
	// 0 good frame, 1 faulty frame, else reply request
	task automatic pulse(input int k);
		case (k)
			0: frame_ok <= 1'b1;
			1: frame_err <= 1'b1;
			default: reply_req <= 1'b1;
		endcase
		@(posedge clk);
		{frame_ok, frame_err, reply_req} <= 3'h0;
		@(posedge clk);
	endtask
endmodule // rsi_host_model

/* verification/rsi_setup_tb.sv */
// self-checking bench for the serial setup and indirect access block
module rsi_setup_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rsi_pkg::*;
	// a short time unit keeps the reply wait within the run budget
	localparam int UNIT_SIM = 4;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, slave_addr, addr_switch;
	logic [31:0] pwdata, prdata, rd;
	logic        frame_ok, frame_err, reply_req, acc_req, acc_we, acc_valid, acc_ind;
	logic [15:0] acc_addr, acc_wdata, acc_target, silent_eff;
	logic [2:0]  rate_code;
	logic [1:0]  word_order, parity_code;
	logic        stop_code, tx_start, err_alarm, err_info, tmo_alarm, exc_resp;
	int          n_errors, checked, n;

	rsi_setup #(.UNIT_CYCLES(UNIT_SIM), .TMO_CYCLES(UNIT_SIM)) rsi_setup_inst (.clk, .rst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .addr_switch, .frame_ok, .frame_err, .reply_req,
		.acc_req, .acc_we, .acc_addr, .acc_wdata, .acc_valid, .acc_ind, .acc_target,
		.slave_addr, .rate_code, .word_order, .parity_code, .stop_code, .silent_eff,
		.tx_start, .err_alarm, .err_info, .tmo_alarm, .exc_resp);
	rsi_host_model rsi_host_model_inst (.clk, .frame_ok, .frame_err, .reply_req,
		.acc_req, .acc_we, .acc_addr, .acc_wdata);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no wait count assumed; only the watchdog ends a hung transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, rd);
		chk("pslverr", 32'(ee), 32'(err));
	endtask
	task automatic link(input logic we, input logic [15:0] a, input logic ind,
			input logic [15:0] tgt);
		rsi_host_model_inst.access(we, a, 16'h5555);
		chk("acc_valid", 32'h1, 32'(acc_valid));
		chk("acc_ind", 32'(ind), 32'(acc_ind));
		chk("acc_target", 32'(tgt), 32'(acc_target));
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		addr_switch = 8'h5a;
		n_errors = 0;
		checked = 0;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(OFS_ID, 32'(RST_ID), 1'b0);
		rchk(OFS_RATE, 32'h4, 1'b0);
		rchk(OFS_ORDER, 32'h0, 1'b0);
		rchk(OFS_PARITY, 32'h1, 1'b0);
		rchk(OFS_STOP, 32'h0, 1'b0);
		rchk(OFS_TXWAIT, 32'h1e, 1'b0);
		rchk(OFS_SILENT, 32'h0, 1'b0);
		rchk(OFS_TMO, 32'h0, 1'b0);
		rchk(OFS_ERRALM, 32'h3, 1'b0);
		rchk(OFS_ERRINF, 32'h3, 1'b0);
		rchk(OFS_ERRMODE, 32'h1, 1'b0);
		rchk(OFS_ACTIVE, 32'h5a24, 1'b0);
		rchk(8'h3c, 32'h0, 1'b1);
		chk("silent_eff", 32'(SIL_AUTO[4]), 32'(silent_eff));
		chk("exc_resp", 32'h1, 32'(exc_resp));
		chk("word_order", 32'(RST_ORDER), 32'(word_order));
		chk("parity_code", 32'(RST_PARITY), 32'(parity_code));
		chk("stop_code", 32'(RST_STOP), 32'(stop_code));
		$display("test defaults done");
		apb(1'b1, OFS_RATE, 32'h2);
		apb(1'b1, OFS_ID, 32'h5);
		chk("rate_code", 32'h4, 32'(rate_code));
		chk("slave_addr", 32'h5a, 32'(slave_addr));
		apb(1'b1, OFS_MAINT, 32'(MNT_PARTIAL));
		rchk(OFS_ID, 32'h5, 1'b0);
		apb(1'b1, OFS_MAINT, 32'(MNT_ALL));
		rchk(OFS_RATE, 32'h4, 1'b0);
		rchk(OFS_ID, 32'(RST_ID), 1'b0);
		apb(1'b1, OFS_ACTIVE, 32'h0);
		rchk(OFS_ACTIVE, 32'h5a24, 1'b0);
		$display("test framing done");
		apb(1'b1, OFS_ERRMODE, 32'h0);
		repeat (2) @(posedge clk);
		chk("exc_resp", 32'h0, 32'(exc_resp));
		apb(1'b1, OFS_ERRALM, 32'h2);
		apb(1'b1, OFS_ERRINF, 32'h2);
		rsi_host_model_inst.pulse(1);
		repeat (3) @(posedge clk);
		chk("err_alarm", 32'h0, 32'(err_alarm));
		rsi_host_model_inst.pulse(1);
		repeat (3) @(posedge clk);
		chk("err_alarm", 32'h1, 32'(err_alarm));
		chk("err_info", 32'h1, 32'(err_info));
		rsi_host_model_inst.pulse(0);
		repeat (3) @(posedge clk);
		chk("err_info", 32'h0, 32'(err_info));
		rchk(OFS_STATUS, 32'h1, 1'b0);
		apb(1'b1, OFS_MAINT, 32'(MNT_ACLR));
		repeat (2) @(posedge clk);
		chk("err_alarm", 32'h0, 32'(err_alarm));
		chk("tmo_alarm", 32'h0, 32'(tmo_alarm));
		$display("test errors done");
		for (int i = 0; i < 2; i++) begin
			// a rewritten wait is only stored; the active wait stays the one loaded at reset
			apb(1'b1, OFS_TXWAIT, 32'(i));
			rsi_host_model_inst.pulse(2);
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (tx_start !== 1'b1 && n < 30000);
			chk("reply wait", 32'(int'(RST_TXWAIT) * UNIT_SIM + 1), 32'(n));
			@(posedge clk);
			chk("tx_start", 32'h0, 32'(tx_start));
		end
		$display("test reply done");
		rsi_host_model_inst.assign_entry(31, 16'h0123);
		link(1'b0, 16'h133f, 1'b1, 16'h0247);
		link(1'b1, 16'h133e, 1'b1, 16'h0246);
		link(1'b0, 16'h1300, 1'b1, 16'h0480);
		link(1'b0, 16'h0480, 1'b0, 16'h0480);
		rchk(OFS_TABLE + 8'h7c, 32'h0123, 1'b0);
		$display("test indirect done");
		complete_run();
	end
	// the whole run needs well under a thousand cycles; this leaves ample margin
	initial begin
		#20000;
		n_errors++;
		complete_run();
	end
endmodule // rsi_setup_tb
